// ===== mts_supervisor.sv
// motor temperature supervisor top: two channels, two-stage reaction
// assumes readings in ohms from converters; chan2_fitted strapped static
`timescale 1ns/1ps
`include "mts_params.svh"
module mts_supervisor import mts_pkg::*; #(
  parameter int unsigned PREWARN_CYC = `MTS_PREWARN_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chan2_fitted,
  input wire logic [15:0] temp_channel_one_lin,
  input wire logic [15:0] temp_channel_one_thr,
  input wire logic [15:0] temp_channel_two_lin,
  input wire logic [15:0] temp_channel_two_thr,
  output logic [15:0] converter_output_port,
  output logic prewarn_active,
  output logic trip_active
);
  mts_chan_if c1();
  mts_chan_if c2();
  mts_state_t state;
  logic [29:0] timer;
  logic fit_s1, fit_s2, armed;
  logic react_any, thr_any, lin_hold;
  mts_ohm_t lin_max, pass_val;

  // both channels use the same monitor
  mts_chan_mon u_ch1 (.clk(clk), .rst_n(rst_n), .lin_ohm(temp_channel_one_lin),
    .thr_ohm(temp_channel_one_thr), .ch(c1.mon));
  mts_chan_mon u_ch2 (.clk(clk), .rst_n(rst_n), .lin_ohm(temp_channel_two_lin),
    .thr_ohm(temp_channel_two_thr), .ch(c2.mon));

  // strap synchroniser; armed on the first clock after reset release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fit_s1 <= 1'b0;
      fit_s2 <= 1'b0;
      armed <= 1'b0;
    end else begin
      fit_s1 <= chan2_fitted;
      fit_s2 <= fit_s1;
      armed <= 1'b1;
    end
  end

  // causes merged over fitted channels
  always_comb begin
    thr_any = c1.thr_flt | (fit_s2 & c2.thr_flt);
    lin_hold = c1.short_flt | c1.wire_flt | (fit_s2 & (c2.short_flt | c2.wire_flt));
    react_any = thr_any | lin_hold;
    lin_max = (fit_s2 && c2.lin > c1.lin) ? c2.lin : c1.lin;
    pass_val = (lin_max < `MTS_FLOOR_OHM) ? `MTS_FLOOR_OHM : lin_max;
  end

  // reaction sequence; all causes clearing, short or wire included, cancels it from prewarn or trip
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= MTS_NORMAL;
      timer <= 30'h00000000;
    end else begin
      case (state)
        MTS_NORMAL: begin
          timer <= 30'h00000000;
          if (armed && react_any) state <= MTS_PREWARN;
        end
        MTS_PREWARN: begin
          if (!react_any) begin
            state <= MTS_NORMAL;
          end else if (timer >= 30'(PREWARN_CYC - 1)) begin
            state <= MTS_TRIP;
          end else begin
            timer <= timer + 30'h00000001;
          end
        end
        MTS_TRIP: begin
          if (!react_any) state <= MTS_NORMAL;
        end
        default: state <= MTS_NORMAL;
      endcase
    end
  end

  // registered output value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      converter_output_port <= `MTS_FLOOR_OHM;
    end else begin
      case (state)
        MTS_PREWARN: converter_output_port <= `MTS_PREWARN_OHM;
        MTS_TRIP: converter_output_port <= `MTS_TRIP_OHM;
        default: converter_output_port <= pass_val;
      endcase
    end
  end

  assign prewarn_active = (state == MTS_PREWARN);
  assign trip_active = (state == MTS_TRIP);

  a_trip_delay: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state == MTS_TRIP) |-> timer >= 30'(PREWARN_CYC - 1))
    else $error("trip before prewarn interval");
  a_prewarn_val: assert property (@(posedge clk) disable iff (!rst_n)
    state == MTS_PREWARN |=> converter_output_port == `MTS_PREWARN_OHM)
    else $error("prewarn value wrong");
  a_trip_val: assert property (@(posedge clk) disable iff (!rst_n)
    state == MTS_TRIP |=> converter_output_port == `MTS_TRIP_OHM)
    else $error("trip value wrong");
  a_start_react: assert property (@(posedge clk) disable iff (!rst_n)
    state == MTS_NORMAL && armed && react_any |=> state == MTS_PREWARN)
    else $error("reaction not started");
  a_cancel: assert property (@(posedge clk) disable iff (!rst_n)
    state == MTS_PREWARN && !react_any |=> state == MTS_NORMAL)
    else $error("reaction not cancelled");
  a_floor_pass: assert property (@(posedge clk) disable iff (!rst_n)
    state == MTS_NORMAL && !react_any |=> converter_output_port >= `MTS_FLOOR_OHM)
    else $error("output under floor");
  a_reset_idle: assert property (@(posedge clk)
    !rst_n |=> state == MTS_NORMAL && timer == 30'h00000000)
    else $error("not idle after reset");
  a_causes: assert property (@(posedge clk) disable iff (!rst_n)
    state == MTS_NORMAL && !react_any |=> state == MTS_NORMAL)
    else $error("reaction without cause");

  c_prewarn: cover property (@(posedge clk) disable iff (!rst_n) state == MTS_PREWARN);
  c_trip: cover property (@(posedge clk) disable iff (!rst_n) state == MTS_TRIP);
  c_cancel: cover property (@(posedge clk) disable iff (!rst_n)
    state == MTS_PREWARN ##1 state == MTS_NORMAL);
endmodule : mts_supervisor

// ===== mts_params.svh
// motor temperature supervisor: thresholds, output values and timing
// assumes resistance words in whole ohms, 16 bits, clock at 250 MHz
// Function
// - with no reaction, pass linear reading to output, floored at 100 ohm.
// - threshold sensor above 1560 ohm starts the reaction at once.
// - two seconds after prewarning, send trip indication to converter.
// - any input below 30 ohm is a short circuit and starts reaction.
// - short-circuit reaction holds until that input rises above 60 ohm.
// - linear input above 1560 ohm is broken wire or overtemperature.
// - wire or overtemperature reaction holds until linear input below 1500 ohm.
// - reaction causes are exactly short circuit, wire break, overtemperature.
// - first stage drives 1340 ohm as prewarning value.
// - two seconds into first stage, output switches to 1800 ohm trip value.
// - threshold sensor below 1500 ohm before two seconds cancels the reaction.
// - two-channel variant evaluates sensors of two parallel motors.
`ifndef MTS_PARAMS_SVH
`define MTS_PARAMS_SVH
`define MTS_W 16
`define MTS_FLOOR_OHM 16'h0064
`define MTS_SHORT_OHM 16'h001E
`define MTS_SHORT_REL_OHM 16'h003C
`define MTS_HIGH_OHM 16'h0618
`define MTS_HIGH_REL_OHM 16'h05DC
`define MTS_PREWARN_OHM 16'h053C
`define MTS_TRIP_OHM 16'h0708
`define MTS_CLK_MHZ 250
`define MTS_PREWARN_MS 2000
`define MTS_PREWARN_CYC (`MTS_PREWARN_MS * 1000 * `MTS_CLK_MHZ)
`endif

// ===== mts_pkg.sv
// motor temperature supervisor types
// assumes mts_params.svh for the numbers
package mts_pkg;
  typedef enum logic [1:0] {MTS_NORMAL, MTS_PREWARN, MTS_TRIP} mts_state_t;
  typedef logic [15:0] mts_ohm_t;
endpackage : mts_pkg

// ===== mts_chan_if.sv
// per-channel fault flags from a channel monitor to the top
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface mts_chan_if;
  logic short_flt;
  logic wire_flt;
  logic thr_flt;
  logic [15:0] lin;
  modport mon (output short_flt, wire_flt, thr_flt, lin);
  modport top (input short_flt, wire_flt, thr_flt, lin);
endinterface : mts_chan_if

// ===== mts_chan_mon.sv
// one temperature channel: synchronises readings, keeps hysteresis flags
// assumes readings arrive asynchronously and settle between samples
`timescale 1ns/1ps
`include "mts_params.svh"
module mts_chan_mon import mts_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] lin_ohm,
  input wire logic [15:0] thr_ohm,
  mts_chan_if.mon ch
);
  mts_ohm_t lin_s1, lin_s2, lin_s3, lin_q, thr_s1, thr_s2, thr_s3, thr_q;
  logic lin_short, thr_short, wire_f, thr_f;

  // two-flop synchroniser for pin-side readings; reset to the floor value,
  // which is neither short nor high, so no false cause follows reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lin_s1 <= `MTS_FLOOR_OHM;
      lin_s2 <= `MTS_FLOOR_OHM;
      thr_s1 <= `MTS_FLOOR_OHM;
      thr_s2 <= `MTS_FLOOR_OHM;
    end else begin
      lin_s1 <= lin_ohm;
      lin_s2 <= lin_s1;
      thr_s1 <= thr_ohm;
      thr_s2 <= thr_s1;
    end
  end

  // word taken only when two samples agree: bits that resolve on
  // different edges never form a false reading (costs two cycles)
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lin_s3 <= `MTS_FLOOR_OHM;
      thr_s3 <= `MTS_FLOOR_OHM;
      lin_q <= `MTS_FLOOR_OHM;
      thr_q <= `MTS_FLOOR_OHM;
    end else begin
      lin_s3 <= lin_s2;
      thr_s3 <= thr_s2;
      if (lin_s2 == lin_s3) lin_q <= lin_s2;
      if (thr_s2 == thr_s3) thr_q <= thr_s2;
    end
  end

  // short flags: set below 30, clear only above 60
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lin_short <= 1'b0;
      thr_short <= 1'b0;
    end else begin
      if (lin_q < `MTS_SHORT_OHM) lin_short <= 1'b1;
      else if (lin_q > `MTS_SHORT_REL_OHM) lin_short <= 1'b0;
      if (thr_q < `MTS_SHORT_OHM) thr_short <= 1'b1;
      else if (thr_q > `MTS_SHORT_REL_OHM) thr_short <= 1'b0;
    end
  end

  // high flags: set above 1560, clear below 1500
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wire_f <= 1'b0;
      thr_f <= 1'b0;
    end else begin
      if (lin_q > `MTS_HIGH_OHM) wire_f <= 1'b1;
      else if (lin_q < `MTS_HIGH_REL_OHM) wire_f <= 1'b0;
      if (thr_q > `MTS_HIGH_OHM) thr_f <= 1'b1;
      else if (thr_q < `MTS_HIGH_REL_OHM) thr_f <= 1'b0;
    end
  end

  assign ch.short_flt = lin_short | thr_short;
  assign ch.wire_flt = wire_f;
  assign ch.thr_flt = thr_f;
  assign ch.lin = lin_q;

  a_short_hyst: assert property (@(posedge clk) disable iff (!rst_n)
    lin_short && lin_q <= `MTS_SHORT_REL_OHM |=> lin_short)
    else $error("short flag left inside hysteresis");
  a_wire_hyst: assert property (@(posedge clk) disable iff (!rst_n)
    wire_f && lin_q >= `MTS_HIGH_REL_OHM |=> wire_f)
    else $error("wire flag left inside hysteresis");
  a_short_set: assert property (@(posedge clk) disable iff (!rst_n)
    lin_q < `MTS_SHORT_OHM |=> lin_short)
    else $error("short not detected");
endmodule : mts_chan_mon

// ===== mts_sensor_model.sv
// partner: digitisers that turn one motor's sensors into readings
// assumes the bench commands the resistances, one clock for all
`timescale 1ns/1ps
module mts_sensor_model import mts_pkg::*; (
  input wire logic clk,
  input wire mts_ohm_t set_lin,
  input wire mts_ohm_t set_thr,
  output mts_ohm_t lin,
  output mts_ohm_t thr
);
  // refresh once per clock, so a change lands a cycle late as on a real converter
  always_ff @(posedge clk) begin
    lin <= set_lin;
    thr <= set_thr;
  end
endmodule : mts_sensor_model

// ===== tb_motor_temp_supervisor.sv
// bench for the supervisor: table of steady readings, then trip and reset cases
// assumes a short prewarn span through the parameter, readings via sensor models
`timescale 1ns/1ps
module tb_motor_temp_supervisor import mts_pkg::*;;
  typedef struct packed {logic fit; mts_ohm_t l1, t1, l2, t2, exp; logic pw;} mts_row_t;
  localparam int ROWS = 16;
  localparam int PW = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fit = 1'b0;
  logic pw, trip;
  mts_ohm_t l1 = 16'h01F4, t1 = 16'h0320, l2 = 16'h0190, t2 = 16'h0320;
  mts_ohm_t sl1, st1, sl2, st2, outp;
  int error_cnt = 0;
  int num_checks = 0;
  // fitted, lin1, thr1, lin2, thr2, expected output, expected prewarn
  mts_row_t rows [ROWS] = '{
    '{1'h0, 16'h01F4, 16'h0320, 16'h0190, 16'h0320, 16'h01F4, 1'h0},
    '{1'h0, 16'h0032, 16'h0320, 16'h0190, 16'h0320, 16'h0064, 1'h0},
    '{1'h0, 16'h0014, 16'h0320, 16'h0190, 16'h0320, 16'h053C, 1'h1},
    '{1'h0, 16'h0032, 16'h0320, 16'h0190, 16'h0320, 16'h053C, 1'h1},
    '{1'h0, 16'h003D, 16'h0320, 16'h0190, 16'h0320, 16'h0064, 1'h0},
    '{1'h0, 16'h003D, 16'h0619, 16'h0190, 16'h0320, 16'h053C, 1'h1},
    '{1'h0, 16'h003D, 16'h05F0, 16'h0190, 16'h0320, 16'h053C, 1'h1},
    '{1'h0, 16'h003D, 16'h05DB, 16'h0190, 16'h0320, 16'h0064, 1'h0},
    '{1'h0, 16'h0619, 16'h0320, 16'h0190, 16'h0320, 16'h053C, 1'h1},
    '{1'h0, 16'h05F0, 16'h0320, 16'h0190, 16'h0320, 16'h053C, 1'h1},
    '{1'h0, 16'h05DB, 16'h0320, 16'h0190, 16'h0320, 16'h05DB, 1'h0},
    '{1'h0, 16'h001E, 16'h001E, 16'h0190, 16'h0320, 16'h0064, 1'h0},
    '{1'h0, 16'h0618, 16'h0320, 16'h0190, 16'h0320, 16'h0618, 1'h0},
    '{1'h1, 16'h0190, 16'h0320, 16'h0384, 16'h0320, 16'h0384, 1'h0},
    '{1'h1, 16'h0190, 16'h0320, 16'h0190, 16'h0014, 16'h053C, 1'h1},
    '{1'h0, 16'h0190, 16'h0320, 16'h0190, 16'h0014, 16'h0190, 1'h0}};

  mts_sensor_model u_mts_sensor_model_a (.clk(clk), .set_lin(l1), .set_thr(t1), .lin(sl1), .thr(st1));
  mts_sensor_model u_mts_sensor_model_b (.clk(clk), .set_lin(l2), .set_thr(t2), .lin(sl2), .thr(st2));
  mts_supervisor #(.PREWARN_CYC(PW)) u_mts_supervisor (.clk(clk), .rst_n(rst_n), .chan2_fitted(fit),
    .temp_channel_one_lin(sl1), .temp_channel_one_thr(st1), .temp_channel_two_lin(sl2),
    .temp_channel_two_thr(st2), .converter_output_port(outp), .prewarn_active(pw), .trip_active(trip));

  always #2 clk = ~clk;

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task print_verdict;
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // 12 cycles covers the ~8 edge latency yet stays well inside the prewarn span
  task apply(input mts_row_t r);
    @(negedge clk);
    {fit, l1, t1, l2, t2} = {r.fit, r.l1, r.t1, r.l2, r.t2};
    repeat (12) @(negedge clk);
  endtask : apply

  initial begin
    repeat (5) @(negedge clk);
    chk(outp, 16'h0064);
    chk({14'h0, pw, trip}, 16'h0000);
    rst_n = 1'b1;
    // healthy readings: no reaction may flicker while the pipeline fills
    repeat (8) begin
      @(negedge clk);
      chk({14'h0, pw, trip}, 16'h0000);
    end
    for (int i = 0; i < ROWS; i++) begin
      apply(rows[i]);
      chk(outp, rows[i].exp);
      chk({15'h0, pw}, {15'h0, rows[i].pw});
    end
    // fault held past the prewarn span must reach the trip value
    apply('{1'h0, 16'h0640, 16'h0320, 16'h0190, 16'h0320, 16'h0000, 1'h0});
    repeat (PW) @(negedge clk);
    chk(outp, 16'h0708);
    chk({14'h0, pw, trip}, 16'h0001);
    // reset in mid-trip with the fault still present
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    chk(outp, 16'h0064);
    chk({14'h0, pw, trip}, 16'h0000);
    @(negedge clk);
    chk(outp, 16'h0064);
    chk({14'h0, pw, trip}, 16'h0000);
    repeat (12) @(negedge clk);
    chk({15'h0, pw}, 16'h0001);
    apply('{1'h0, 16'h03E8, 16'h0320, 16'h0190, 16'h0320, 16'h0000, 1'h0});
    chk(outp, 16'h03E8);
    print_verdict;
  end

  // whole run is some 300 cycles; this limit leaves ample margin
  initial begin
    #8000;
    error_cnt++;
    print_verdict;
  end
endmodule : tb_motor_temp_supervisor
